// ---- hw/prdt_pkg.sv ----
package prdt_pkg;

  // system clock and the fixed tap ladder of the count source
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TOP_TAP_HZ  = 8192;
  localparam int unsigned BASE_HZ     = 2 * TOP_TAP_HZ;
  // rounds down: fastest tap runs a hair fast, well within crystal slop
  localparam logic [10:0] BASE_DIV    = 11'(CLK_HZ / BASE_HZ);
  localparam int unsigned TAP_W       = 6;
  localparam int unsigned SAMPLE_HZ   = 256;
  localparam logic [5:0]  SAMPLE_WRAP = 6'(BASE_HZ / SAMPLE_HZ - 1);

  // register indices; byte address is four times the index
  localparam int unsigned ADR_W            = 14;
  localparam logic [11:0] IDX_IRQ_FLAG     = 12'hf02;
  localparam logic [11:0] IDX_IRQ_MASK     = 12'hf12;
  localparam logic [11:0] IDX_COUNT_LOW    = 12'hf24;
  localparam logic [11:0] IDX_COUNT_HIGH   = 12'hf25;
  localparam logic [11:0] IDX_RELOAD_LOW   = 12'hf26;
  localparam logic [11:0] IDX_RELOAD_HIGH  = 12'hf27;
  localparam logic [11:0] IDX_RUN_CTRL     = 12'hf78;
  localparam logic [11:0] IDX_CLK_SEL      = 12'hf79;

  // field positions
  localparam int unsigned FLAG_BIT         = 0;
  localparam int unsigned MASK_BIT         = 0;
  localparam int unsigned RUN_BIT          = 0;
  localparam int unsigned RELOAD_STB_BIT   = 1;
  localparam int unsigned SEL_LSB          = 0;
  localparam int unsigned CLKOUT_BIT       = 3;

  // reset values
  localparam logic        FLAG_RST         = 1'b0;
  localparam logic        MASK_RST         = 1'b0;
  localparam logic        RUN_RST          = 1'b0;
  localparam logic        CLKOUT_RST       = 1'b0;
  localparam logic [7:0]  COUNT_RST        = 8'h00;
  localparam logic [7:0]  RELOAD_RST       = 8'h00;

  typedef enum logic [2:0] {
    SRC_PIN_FILTERED = 3'b000,
    SRC_PIN_DIRECT   = 3'b001,
    SRC_256HZ        = 3'b010,
    SRC_512HZ        = 3'b011,
    SRC_1024HZ       = 3'b100,
    SRC_2048HZ       = 3'b101,
    SRC_4096HZ       = 3'b110,
    SRC_8192HZ       = 3'b111
  } src_e;

  localparam src_e SEL_RST = SRC_PIN_FILTERED;

endpackage

// ---- hw/count_clk_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface count_clk_if;
  import prdt_pkg::*;

  src_e sel;
  logic level;
  logic fall;

  modport source (
    input  sel,
    output level,
    output fall
  );

  modport user (
    output sel,
    input  level,
    input  fall
  );
endinterface

`default_nettype wire

// ---- hw/count_clock_source.sv ----
`timescale 1ns/100ps
`default_nettype none

module count_clock_source (
  input  wire logic   mclk,
  input  wire logic   srst,
  input  wire logic   ce,
  input  wire logic   external_count_pin,
  count_clk_if.source cs
);
  import prdt_pkg::*;

  typedef struct packed {
    logic [10:0]      div;
    logic [TAP_W-1:0] tap;
    logic             pin_meta;
    logic             pin_sync;
    logic             last_sample;
    logic             filtered;
    logic             level;
    logic             fall;
  } src_state_s;

  src_state_s st;
  src_state_s next_st;

  always_comb begin
    logic       base_tick;
    logic       sample_tick;
    logic       picked;
    logic [2:0] tap_sel;
    base_tick   = 1'b0;
    sample_tick = 1'b0;
    picked      = 1'b0;
    tap_sel     = 3'h0;
    next_st     = st;
    if (ce) begin
      base_tick   = (st.div == BASE_DIV - 11'h1);
      sample_tick = base_tick && (st.tap == SAMPLE_WRAP);
      next_st.div = base_tick ? 11'h0 : st.div + 11'h1;
      if (base_tick) begin
        next_st.tap = st.tap + 6'h1;
      end
      // second stage only feeds logic; first stage read by nothing else
      next_st.pin_meta = external_count_pin;
      next_st.pin_sync = st.pin_meta;
      // two agreeing 256 Hz samples: short chatter never survives
      if (sample_tick) begin
        next_st.last_sample = st.pin_sync;
        if (st.pin_sync == st.last_sample) begin
          next_st.filtered = st.pin_sync;
        end
      end
      tap_sel = 3'h7 - 3'(cs.sel);
      case (cs.sel)
        SRC_PIN_FILTERED: picked = st.filtered;
        SRC_PIN_DIRECT:   picked = st.pin_sync;
        default:          picked = st.tap[tap_sel];
      endcase
      next_st.level = picked;
      next_st.fall  = st.level & ~picked;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cs.level = st.level;
  assign cs.fall  = st.fall;

endmodule

`default_nettype wire

// ---- hw/programmable_reload_down_timer.sv ----
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module programmable_reload_down_timer (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              external_count_pin,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [prdt_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  output var  logic              underflow_irq_req,
  output var  logic              shared_output_pin
);
  import prdt_pkg::*;

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] reload_value;
    logic       count_run_bit;
    logic       underflow_irq_mask;
    logic       underflow_irq_flag;
    src_e       count_source_select;
    logic       count_clock_out_enable;
    logic       ack;
    logic [3:0] rdata;
    logic       irq_req;
    logic       clk_out;
  } timer_state_s;

  timer_state_s st;
  timer_state_s next_st;

  count_clk_if cclk ();

  assign cclk.sel = st.count_source_select;

  count_clock_source u_source (
    .mclk               (mclk),
    .srst               (srst),
    .ce                 (ce),
    .external_count_pin (external_count_pin),
    .cs                 (cclk)
  );

  always_comb begin
    logic        access;
    logic        wr;
    logic        rd;
    logic [11:0] idx;
    logic        count_reload_strobe;
    logic        hit_zero;
    logic [7:0]  dec;
    access              = 1'b0;
    wr                  = 1'b0;
    rd                  = 1'b0;
    idx                 = 12'h0;
    count_reload_strobe = 1'b0;
    hit_zero            = 1'b0;
    dec                 = 8'h0;
    next_st             = st;

    if (ce) begin
      // one request per ack; the idle cycle after ack blocks a double take
      access = wb_cyc_i & wb_stb_i & ~st.ack;
      idx    = wb_adr_i[ADR_W-1:2];
      wr     = access & wb_we_i & wb_sel_i[0];
      rd     = access & ~wb_we_i;

      next_st.ack   = access;
      next_st.rdata = 4'h0;

      if (rd) begin
        case (idx)
          IDX_IRQ_FLAG: begin
            next_st.rdata[FLAG_BIT] = st.underflow_irq_flag;
          end
          IDX_IRQ_MASK: begin
            next_st.rdata[MASK_BIT] = st.underflow_irq_mask;
          end
          IDX_COUNT_LOW: begin
            next_st.rdata = st.count_value[3:0];
          end
          IDX_COUNT_HIGH: begin
            next_st.rdata = st.count_value[7:4];
          end
          IDX_RELOAD_LOW: begin
            next_st.rdata = st.reload_value[3:0];
          end
          IDX_RELOAD_HIGH: begin
            next_st.rdata = st.reload_value[7:4];
          end
          IDX_RUN_CTRL: begin
            // strobe bit has no storage and reads zero
            next_st.rdata[RUN_BIT] = st.count_run_bit;
          end
          IDX_CLK_SEL: begin
            next_st.rdata[SEL_LSB+:3]  = 3'(st.count_source_select);
            next_st.rdata[CLKOUT_BIT] = st.count_clock_out_enable;
          end
          default: begin
            next_st.rdata = 4'h0;
          end
        endcase
      end

      if (wr) begin
        case (idx)
          IDX_IRQ_MASK: begin
            next_st.underflow_irq_mask = wb_dat_i[MASK_BIT];
          end
          IDX_RELOAD_LOW: begin
            next_st.reload_value[3:0] = wb_dat_i[3:0];
          end
          IDX_RELOAD_HIGH: begin
            next_st.reload_value[7:4] = wb_dat_i[3:0];
          end
          IDX_RUN_CTRL: begin
            next_st.count_run_bit = wb_dat_i[RUN_BIT];
            count_reload_strobe   = wb_dat_i[RELOAD_STB_BIT];
          end
          IDX_CLK_SEL: begin
            next_st.count_source_select    = src_e'(wb_dat_i[SEL_LSB+:3]);
            next_st.count_clock_out_enable = wb_dat_i[CLKOUT_BIT];
          end
          default: begin
            // flag, count and unmapped words ignore writes
            next_st.count_run_bit = st.count_run_bit;
          end
        endcase
      end

      // strobe outranks a same-cycle count step
      if (count_reload_strobe) begin
        next_st.count_value = st.reload_value;
      end else if (st.count_run_bit && cclk.fall) begin
        // reaching zero reloads at once: reload 00 walks 00,ff..01
        dec = st.count_value - 8'h1;
        if (dec == 8'h00) begin
          hit_zero            = 1'b1;
          next_st.count_value = st.reload_value;
        end else begin
          next_st.count_value = dec;
        end
      end
      // only the reload strobe touches count while stopped; otherwise it holds

      // a read clears the flag, but a new underflow wins
      if (rd && idx == IDX_IRQ_FLAG) begin
        next_st.underflow_irq_flag = 1'b0;
      end
      if (hit_zero) begin
        next_st.underflow_irq_flag = 1'b1;
      end

      next_st.irq_req = st.underflow_irq_flag & st.underflow_irq_mask;
      next_st.clk_out = st.count_clock_out_enable & cclk.level;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st                        <= '0;
      st.count_value            <= COUNT_RST;
      st.reload_value           <= RELOAD_RST;
      st.count_run_bit          <= RUN_RST;
      st.underflow_irq_mask     <= MASK_RST;
      st.underflow_irq_flag     <= FLAG_RST;
      st.count_source_select    <= SEL_RST;
      st.count_clock_out_enable <= CLKOUT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o          = {28'h0, st.rdata};
  assign wb_ack_o          = st.ack;
  assign underflow_irq_req = st.irq_req;
  assign shared_output_pin = st.clk_out;

endmodule

`default_nettype wire

// ---- dv/prdt_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none

module prdt_assertions (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  import prdt_pkg::*;
  logic        rd;
  logic [11:0] idx;
  // read data is judged at the ack edge, where the master takes it
  assign rd = wb_ack_o && !wb_we_i;
  assign idx = wb_adr_i[13:2];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_answer; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_dat_upper; wb_dat_o[31:4] == 28'h0; endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("wide data");
  property p_flag_read; rd && idx == IDX_IRQ_FLAG |-> wb_dat_o[3:1] == 3'h0; endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag high bits");
  property p_mask_read; rd && idx == IDX_IRQ_MASK |-> wb_dat_o[3:1] == 3'h0; endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask high bits");
  property p_ctrl_read; rd && idx == IDX_RUN_CTRL |-> wb_dat_o[3:1] == 3'h0; endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("strobe reads one");
endmodule

bind programmable_reload_down_timer prdt_assertions u_prdt_assertions (
  .mclk, .srst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o
);

`default_nettype wire

// ---- dv/count_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module count_pin_model (
  input  wire logic mclk,
  input  wire logic go,
  output var  logic pin
);
  logic [2:0] tick = 3'h0;
  // level stands still between bursts, like a key left alone
  logic       lvl  = 1'b1;
  assign pin = lvl;
  always @(posedge mclk) begin
    tick <= tick + 3'h1;
    if (go && tick == 3'h7) lvl <= !lvl;
  end
endmodule

`default_nettype wire

// ---- dv/programmable_reload_down_timer_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module programmable_reload_down_timer_test;
  import prdt_pkg::*;
  logic        mclk;
  logic        srst = 1'b1;
  logic        go = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  be = 4'hf;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        pin, ack, irq, opin, w;
  logic [7:0]  q, r, e, c;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          k, n, p;
  // reset-zero registers, then one unmapped index
  logic [11:0] zi [5] = '{IDX_IRQ_FLAG, IDX_IRQ_MASK, IDX_RUN_CTRL, IDX_CLK_SEL, 12'hf03};

  count_pin_model u_pin (.mclk(mclk), .go(go), .pin(pin));
  programmable_reload_down_timer u_dut (
    .mclk(mclk), .srst(srst), .ce(ce), .external_count_pin(pin), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .underflow_irq_req(irq), .shared_output_pin(opin)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      error_cnt++;
      finish_test();
    end
  end

  function automatic logic [8:0] model(input logic [7:0] rl, input int steps);
    logic [8:0] v;
    v = {1'b0, rl};
    repeat (steps) v = (v[7:0] == 8'h01) ? {1'b1, rl} : {v[8], v[7:0] - 8'h01};
    return v;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [3:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    dat <= {28'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = {4'h0, rdat[3:0]};
    cyc <= 1'b0;
  endtask

  task automatic count();
    bus(1'b0, IDX_COUNT_LOW, 4'h0);
    c[3:0] = q[3:0];
    bus(1'b0, IDX_COUNT_HIGH, 4'h0);
    c[7:4] = q[3:0];
  endtask

  task automatic zero_regs();
    foreach (zi[i]) begin
      bus(1'b0, zi[i], 4'h0);
      check(q, 8'h00);
    end
    check({7'h0, opin}, 8'h00);
    check({7'h0, irq}, 8'h00);
    $display("reset values test done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hd86b));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    bus(1'b1, IDX_IRQ_FLAG, 4'h1);
    zero_regs();
    // a write without its low byte lane must not land
    be <= 4'h0;
    bus(1'b1, IDX_IRQ_MASK, 4'h1);
    be <= 4'hf;
    bus(1'b0, IDX_IRQ_MASK, 4'h0);
    check(q, 8'h00);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, IDX_CLK_SEL, 4'(s));
      bus(1'b0, IDX_CLK_SEL, 4'h0);
      check(q, 8'(s));
    end
    bus(1'b1, IDX_CLK_SEL, 4'h1);
    for (int t = 0; t < 4; t++) begin
      r = (t < 2) ? 8'(t) : 8'($urandom_range(255, 2));
      k = $urandom_range(300, 1);
      {w, e} = model(r, k);
      bus(1'b1, IDX_IRQ_MASK, 4'(t % 2));
      bus(1'b1, IDX_RELOAD_LOW, r[3:0]);
      bus(1'b1, IDX_RELOAD_HIGH, r[7:4]);
      bus(1'b1, IDX_RUN_CTRL, 4'h2);
      count();
      check(c, r);
      bus(1'b1, IDX_RUN_CTRL, 4'h1);
      bus(1'b0, IDX_RUN_CTRL, 4'h0);
      check(q, 8'h01);
      go <= 1'b1;
      repeat (k) @(negedge pin);
      @(posedge mclk);
      go <= 1'b0;
      // a fall takes a few cycles through the synchroniser
      repeat (8) @(posedge mclk);
      bus(1'b1, IDX_RUN_CTRL, 4'h0);
      go <= 1'b1;
      repeat (5) @(negedge pin);
      @(posedge pin);
      @(posedge mclk);
      go <= 1'b0;
      bus(1'b1, IDX_COUNT_LOW, ~e[3:0]);
      count();
      check(c, e);
      check({7'h0, irq}, {7'h0, w & t[0]});
      bus(1'b0, IDX_IRQ_FLAG, 4'h0);
      check(q, {7'h0, w});
      bus(1'b0, IDX_IRQ_FLAG, 4'h0);
      check(q, 8'h00);
      // pin sits high here; a disabled clock output must stay low
      check({7'h0, opin}, 8'h00);
      $display("pin test %0d done", t);
    end
    bus(1'b1, IDX_RELOAD_HIGH, 4'h8);
    bus(1'b1, IDX_RELOAD_LOW, 4'h0);
    bus(1'b1, IDX_RUN_CTRL, 4'h2);
    bus(1'b1, IDX_CLK_SEL, 4'hf);
    @(negedge opin);
    bus(1'b1, IDX_RUN_CTRL, 4'h1);
    @(negedge opin);
    n = cycles;
    @(negedge opin);
    p = CLK_HZ / TOP_TAP_HZ;
    check(8'(cycles - n > p - p / 64 && cycles - n < p + p / 64), 8'h01);
    // frozen longer than a tap period: no step may be taken meanwhile
    @(posedge mclk);
    ce <= 1'b0;
    repeat (4000) @(posedge mclk);
    ce <= 1'b1;
    repeat (20) @(posedge mclk);
    bus(1'b1, IDX_RUN_CTRL, 4'h0);
    count();
    check(c, 8'h7e);
    $display("tap test done");
    // second reset with the run bit cleared, with mask, select and clock out set
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    zero_regs();
    finish_test();
  end
endmodule

`default_nettype wire
